// >>> nor_flash_host.sv
/*
  host side controller for a 4m x16 parallel nor flash: sequences reads,
  page reads, unlocked program, erase, write-buffer program and reset.
  assumes flash pins are synchronous to mclk_in; the board resolves the
  shared data wire from pins_out.dq_oe.
*/
`timescale 1ns/100ps
module nor_flash_host
  import nor_host_pkg::*;
(
  // clock, reset, enable
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ce_in,
  // request side
  input  wire logic              req_valid_in,
  input  req_t                   req_in,
  output logic                   req_ready_out,
  output logic                   rsp_valid_out,
  output logic [DATA_W-1:0]      rsp_data_out,
  output logic                   rsp_refused_out,
  // buffer fill for write-buffer program
  input  wire logic              buf_wr_in,
  input  wire logic [BUF_AW-1:0] buf_addr_in,
  input  wire logic [DATA_W-1:0] buf_data_in,
  // flash pins
  output pins_t                  pins_out,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic              ready_busy_in,
  input  wire logic              write_protect_n_in
);

  typedef enum logic [3:0] {
    S_IDLE, S_READ, S_WR_SETUP, S_WR_PULSE, S_WR_HOLD, S_NEXT,
    S_POLL, S_RESET, S_DONE
  } state_t;

  typedef struct packed {
    state_t            st;
    req_t              req;
    pins_t             pins;
    logic [TMR_W-1:0]  tmr;
    logic [3:0]        step;
    logic [BUF_AW-1:0] widx;
    logic [DATA_W-1:0] last;
    logic              poll_first;
    logic              page_ok;
    logic [ADDR_W-1:0] page_addr;
    logic              rsp_valid;
    logic              refused;
    logic [DATA_W-1:0] rsp_data;
  } ctl_t;

  ctl_t              s_reg;
  ctl_t              s_next;
  logic [DATA_W-1:0] buf_rdata;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // boot block zero
  function automatic logic in_boot(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:BLOCK_LSB] == BOOT_BLOCK;
  endfunction

  function automatic logic same_page(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] b);
    return a[ADDR_W-1:PAGE_W] == b[ADDR_W-1:PAGE_W];
  endfunction

  function automatic logic [TMR_W-1:0] cyc(input int n);
    return TMR_W'(n);
  endfunction

  nor_word_buf u_buf (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .ce_in     (ce_in),
    .wr_in     (buf_wr_in),
    .waddr_in  (buf_addr_in),
    .wdata_in  (buf_data_in),
    // read ahead on the next index: the store's output lags one edge,
    // so the word must already stand when the setup step latches it
    .raddr_in  (s_next.widx),
    .rdata_out (buf_rdata)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // word written in each step of the current operation
  always_comb begin
    logic [ADDR_W-1:0] wa;
    logic [DATA_W-1:0] wd;
    logic              last_step;
    wa = '0;
    wd = '0;
    last_step = 1'b0;
    s_next = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.refused   = 1'b0;
    case (s_reg.step)
      4'h0: begin
        wa = UNLOCK_ADDR1;
        wd = UNLOCK_DATA1;
      end
      4'h1: begin
        wa = UNLOCK_ADDR2;
        wd = UNLOCK_DATA2;
      end
      default: begin
        wa = s_reg.req.addr;
        wd = s_reg.req.data;
      end
    endcase
    case (s_reg.req.op)
      OP_PROGRAM: begin
        if (s_reg.step == 4'h2) begin
          wa = UNLOCK_ADDR1;
          wd = CMD_PROGRAM;
        end
        last_step = s_reg.step == 4'h3;
      end
      OP_SECTOR_ERASE, OP_BLOCK_ERASE: begin
        if (s_reg.step == 4'h2) begin
          wa = UNLOCK_ADDR1;
          wd = CMD_ERASE;
        end else if (s_reg.step == 4'h3) begin
          wa = UNLOCK_ADDR1;
          wd = UNLOCK_DATA1;
        end else if (s_reg.step == 4'h4) begin
          wa = UNLOCK_ADDR2;
          wd = UNLOCK_DATA2;
        end else if (s_reg.step == 4'h5) begin
          wa = (s_reg.req.op == OP_SECTOR_ERASE)
             ? {s_reg.req.addr[ADDR_W-1:SECTOR_LSB], 12'h000}
             : {s_reg.req.addr[ADDR_W-1:BLOCK_LSB], 15'h0000};
          wd = (s_reg.req.op == OP_SECTOR_ERASE) ? CMD_SECTOR : CMD_BLOCK;
        end
        last_step = s_reg.step == 4'h5;
      end
      OP_BUF_PROGRAM: begin
        if (s_reg.step == 4'h2) begin
          wd = CMD_WBUF;
        end else if (s_reg.step == 4'h3) begin
          wd = {12'h000, s_reg.req.count};
        end else if (s_reg.step == 4'h4) begin
          wa = {s_reg.req.addr[ADDR_W-1:BUF_AW], s_reg.widx};
          wd = buf_rdata;
        end else if (s_reg.step == 4'h5) begin
          wd = CMD_WBUF_GO;
        end
        last_step = s_reg.step == 4'h5;
      end
      default: begin
        wd = CMD_RESET;
        last_step = 1'b1;
      end
    endcase

    if (s_reg.tmr != '0) begin
      s_next.tmr = s_reg.tmr - 1'b1;
    end

    case (s_reg.st)
      S_IDLE: begin
        s_next.pins.ce_n  = 1'b1;
        s_next.pins.oe_n  = 1'b1;
        s_next.pins.we_n  = 1'b1;
        s_next.pins.dq_oe = 1'b0;
        if (req_valid_in) begin
          s_next.req  = req_in;
          s_next.step = 4'h0;
          s_next.widx = '0;
          if (req_in.op == OP_READ) begin
            s_next.pins.ce_n = 1'b0;
            s_next.pins.oe_n = 1'b0;
            s_next.pins.addr = req_in.addr;
            s_next.st = S_READ;
            s_next.tmr = (s_reg.page_ok && same_page(req_in.addr,
                          s_reg.page_addr)) ? cyc(CYC_PAGE)
                                            : cyc(CYC_RANDOM);
          end else if (req_in.op == OP_RESET) begin
            s_next.pins.rst_n = 1'b0;
            s_next.tmr = cyc(CYC_RST);
            s_next.page_ok = 1'b0;
            s_next.st = S_RESET;
          end else if (!write_protect_n_in && in_boot(req_in.addr)) begin
            s_next.refused = 1'b1;
            s_next.rsp_valid = 1'b1;
          end else begin
            s_next.page_ok = 1'b0;
            s_next.st = S_WR_SETUP;
          end
        end
      end
      S_READ: begin
        if (s_reg.tmr == '0) begin
          s_next.rsp_data  = dq_in;
          s_next.page_ok   = 1'b1;
          s_next.page_addr = s_reg.req.addr;
          s_next.pins.oe_n = 1'b1;
          s_next.pins.ce_n = 1'b1;
          s_next.st = S_DONE;
        end
      end
      S_WR_SETUP: begin
        s_next.pins.oe_n  = 1'b1;
        s_next.pins.ce_n  = 1'b0;
        s_next.pins.addr  = wa;
        s_next.pins.dq_o  = wd;
        s_next.pins.dq_oe = 1'b1;
        s_next.pins.we_n  = 1'b0;
        s_next.tmr = cyc(CYC_WE);
        s_next.st = S_WR_PULSE;
      end
      S_WR_PULSE: begin
        if (s_reg.tmr == '0) begin
          s_next.pins.we_n = 1'b1;
          s_next.tmr = cyc(CYC_HOLD);
          s_next.st = S_WR_HOLD;
        end
      end
      S_WR_HOLD: begin
        if (s_reg.tmr == '0) begin
          s_next.pins.dq_oe = 1'b0;
          s_next.pins.ce_n  = 1'b1;
          s_next.st = S_NEXT;
        end
      end
      S_NEXT: begin
        s_next.st = S_WR_SETUP;
        if (s_reg.req.op == OP_BUF_PROGRAM && s_reg.step == 4'h4 &&
            s_reg.widx != s_reg.req.count) begin
          s_next.widx = s_reg.widx + 1'b1;
        end else if (last_step) begin
          s_next.poll_first = 1'b1;
          s_next.st = S_POLL;
        end else begin
          s_next.step = s_reg.step + 1'b1;
        end
      end
      S_POLL: begin
        s_next.pins.ce_n = 1'b0;
        s_next.pins.oe_n = 1'b0;
        if (s_reg.tmr == '0 && !s_reg.pins.oe_n) begin
          s_next.last = dq_in;
          s_next.poll_first = 1'b0;
          s_next.pins.oe_n = 1'b1;
          s_next.tmr = cyc(CYC_RANDOM);
          if (!s_reg.poll_first && ready_busy_in &&
              dq_in[POLL_TOGGLE_BIT] == s_reg.last[POLL_TOGGLE_BIT]) begin
            s_next.pins.ce_n = 1'b1;
            s_next.rsp_data = dq_in;
            s_next.st = S_DONE;
          end
        end
      end
      S_RESET: begin
        if (s_reg.tmr == '0) begin
          s_next.pins.rst_n = 1'b1;
          s_next.st = S_DONE;
        end
      end
      default: begin
        s_next.rsp_valid = 1'b1;
        s_next.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg <= '{st: S_IDLE, req: '0,
                 pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1,
                         addr: '0, dq_o: '0, dq_oe: 1'b0},
                 tmr: '0, step: '0, widx: '0, last: '0,
                 poll_first: 1'b0, page_ok: 1'b0, page_addr: '0,
                 rsp_valid: 1'b0, refused: 1'b0, rsp_data: '0};
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  assign req_ready_out   = ce_in && (s_reg.st == S_IDLE) && !s_reg.rsp_valid;
  assign rsp_valid_out   = s_reg.rsp_valid;
  assign rsp_data_out    = s_reg.rsp_data;
  assign rsp_refused_out = s_reg.refused;
  assign pins_out        = s_reg.pins;

endmodule

// >>> nor_host_pkg.sv
/*
  constants and carrier types for the parallel nor flash host controller.
  assumes a 100 mhz system clock and an x16 flash with 22 word address bits.
*/
package nor_host_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W      = 22;
  localparam int DATA_W      = 16;
  localparam int SECTOR_LSB  = 12;
  localparam int BLOCK_LSB   = 15;
  localparam int PAGE_W      = 4;
  localparam int BUF_DEPTH   = 16;
  localparam int BUF_AW      = 4;
  localparam logic [6:0] BOOT_BLOCK = 7'h00;

  // ---------------------------------------------------------------
  // unlock and command words
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 22'h00_0555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 22'h00_02AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROGRAM  = 16'h00A0;
  localparam logic [DATA_W-1:0] CMD_ERASE    = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_SECTOR   = 16'h0050;
  localparam logic [DATA_W-1:0] CMD_BLOCK    = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_WBUF     = 16'h0025;
  localparam logic [DATA_W-1:0] CMD_WBUF_GO  = 16'h0029;
  localparam logic [DATA_W-1:0] CMD_RESET    = 16'h00F0;
  localparam int POLL_TOGGLE_BIT = 6;
  localparam int POLL_DATA_BIT   = 7;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int T_RANDOM_NS    = 70;
  localparam int T_PAGE_NS      = 25;
  localparam int T_WE_PULSE_NS  = 40;
  localparam int T_HOLD_NS      = 30;
  localparam int T_RST_PULSE_NS = 500;
  localparam int CYC_RANDOM  = (T_RANDOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_PAGE    = (T_PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_WE      = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int CYC_HOLD    = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RST     = (T_RST_PULSE_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int TMR_W = 8;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE,
    OP_BUF_PROGRAM, OP_RESET
  } op_t;

  typedef struct packed {
    op_t               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [BUF_AW-1:0] count;
  } req_t;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              rst_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic              dq_oe;
  } pins_t;

endpackage

// >>> nor_word_buf.sv
/*
  small word store holding data for a write-buffer program.
  assumes one writer and one reader in the controller clock domain.
*/
`timescale 1ns/100ps
module nor_word_buf
  import nor_host_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ce_in,
  // write side
  input  wire logic              wr_in,
  input  wire logic [BUF_AW-1:0] waddr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  // read side, data registered
  input  wire logic [BUF_AW-1:0] raddr_in,
  output logic      [DATA_W-1:0] rdata_out
);

  logic [DATA_W-1:0] mem [BUF_DEPTH];

  always_ff @(posedge mclk_in) begin
    if (ce_in && wr_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 16'h0000;
    end else if (ce_in) begin
      rdata_out <= mem[raddr_in];
    end
  end

endmodule

// >>> nor_flash_host_assertions.sv
/*
  port checks for the nor flash host controller.
  assumes a bind onto nor_flash_host in the bench's top file.
*/
`timescale 1ns/100ps
module nor_flash_host_assertions
  import nor_host_pkg::*;
(
  // clock and request side
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  input  wire logic req_valid_in,
  input  req_t      req_in,
  input  wire logic req_ready_out,
  input  wire logic rsp_valid_out,
  input  wire logic rsp_refused_out,
  // flash pins
  input  pins_t     pins_out,
  input  wire logic ready_busy_in,
  input  wire logic write_protect_n_in
);
  localparam int RD_MIN = 4;
  localparam int RD_MAX = 10;
  logic taken;
  logic wr_op;
  logic prot;
  logic wr_reg;
  // ------------------------------------------------
  // helpers and checks
  // ------------------------------------------------
  assign taken = ce_in && req_valid_in && req_ready_out;
  assign wr_op = req_in.op inside {OP_PROGRAM, OP_SECTOR_ERASE,
                                   OP_BLOCK_ERASE, OP_BUF_PROGRAM};
  assign prot  = wr_op && req_in.addr[21:15] == BOOT_BLOCK
                 && !write_protect_n_in;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_reg <= 1'b0;
    end else if (taken) begin
      wr_reg <= wr_op;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_prot_take;
    taken && prot;
  endsequence
  sequence s_refusal;
    rsp_valid_out && rsp_refused_out;
  endsequence
  a_refuse_boot: assert property (
    s_prot_take |-> ##[1:2] s_refusal) else $error("no refusal");
  a_refuse_quiet: assert property (
    s_prot_take |=> (pins_out.ce_n && pins_out.we_n) [*2])
    else $error("bus cycle on refused op");
  a_write_in_ce: assert property (
    !pins_out.we_n |-> !pins_out.ce_n) else $error("we without ce");
  a_write_drives: assert property (
    !pins_out.we_n |-> pins_out.oe_n && pins_out.dq_oe)
    else $error("write without data drive");
  a_read_floats: assert property (
    !pins_out.oe_n |-> !pins_out.dq_oe) else $error("host drives on read");
  a_read_gates: assert property (
    taken && req_in.op == OP_READ |-> ##[1:2]
    (!pins_out.ce_n && !pins_out.oe_n)) else $error("read not gated");
  a_read_bounded: assert property (
    taken && req_in.op == OP_READ |-> ##[RD_MIN:RD_MAX] rsp_valid_out)
    else $error("read answer late");
  a_reset_pulse: assert property (
    $fell(pins_out.rst_n) |-> !pins_out.rst_n [*8])
    else $error("reset pulse short");
  a_done_ready: assert property (
    rsp_valid_out && wr_reg && !rsp_refused_out |-> $past(ready_busy_in))
    else $error("done while busy");
endmodule

// >>> nor_flash_model.sv
/*
  behavioural flash device answering the host controller's pins.
  assumes the package's unlock and command words.
*/
`timescale 1ns/100ps
module nor_flash_model
  import nor_host_pkg::*;
#(
  parameter real T_PROG_NS  = 1000.0,
  parameter real T_ERASE_NS = 5000.0
)
(
  // flash pins
  input  pins_t                  pins_in,
  input  wire logic [DATA_W-1:0] data_bus_in,
  input  wire logic              write_protect_n_in,
  output logic      [DATA_W-1:0] data_bus_out,
  output logic                   ready_busy_out
);
  logic [DATA_W-1:0]        mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0]        pend [logic [ADDR_W-1:0]];
  logic [ADDR_W+DATA_W-1:0] h [$];
  logic [ADDR_W-1:0]        ca = '0;
  logic                     was = 0, pw = 0, tog = 0, pv = 0;
  logic                     sel, busy, act;
  int                       wbs = 0, left = 0;
  real                      t0 = 0.0, acc = 0.0, busy_to = 0.0;
  // ------------------------------------------------
  // array and command decode
  // ------------------------------------------------
  function automatic logic [DATA_W-1:0] rdm(input logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  function automatic bit at(input int k, input logic [ADDR_W-1:0] a,
                            input logic [DATA_W-1:0] d);
    return h.size() > k && h[h.size()-1-k] == {a, d};
  endfunction
  function automatic bit ul(input int k);
    return at(k+1, UNLOCK_ADDR1, UNLOCK_DATA1)
           && at(k, UNLOCK_ADDR2, UNLOCK_DATA2);
  endfunction
  function automatic bit guard(input logic [ADDR_W-1:0] a);
    return !write_protect_n_in && a[21:15] == BOOT_BLOCK;
  endfunction
  task automatic prog(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    if (!guard(a)) begin
      mem[a] = rdm(a) & d;
      busy_to = $realtime + T_PROG_NS;
    end
  endtask
  task automatic erase(input logic [ADDR_W-1:0] a, input int lsb);
    if (!guard(a)) begin
      foreach (mem[k]) begin
        if ((k >> lsb) == (a >> lsb)) mem[k] = 16'hFFFF;
      end
      busy_to = $realtime + T_ERASE_NS;
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    h.push_back({a, d});
    pv = 1'b0;
    case (wbs)
      1: begin
        left = int'(d) + 1;
        wbs = 2;
      end
      2: begin
        pend[a] = d;
        left--;
        if (left == 0) wbs = 3;
      end
      3: begin
        if (d == CMD_WBUF_GO) begin
          foreach (pend[k]) prog(k, pend[k]);
        end
        pend.delete();
        wbs = 0;
      end
      default: begin
        if (ul(1) && d == CMD_WBUF) wbs = 1;
        else if (ul(2) && at(1, UNLOCK_ADDR1, CMD_PROGRAM)) prog(a, d);
        else if (ul(4) && at(3, UNLOCK_ADDR1, CMD_ERASE) && ul(1)) begin
          if (d == CMD_SECTOR) erase(a, SECTOR_LSB);
          if (d == CMD_BLOCK) erase(a, BLOCK_LSB);
        end
      end
    endcase
  endtask
  // ------------------------------------------------
  // pin behaviour, half a ns off the clock edges
  // ------------------------------------------------
  initial begin
    data_bus_out = 16'h0000;
    ready_busy_out = 1'b1;
    #0.5;
    forever begin
      sel = !pins_in.ce_n && !pins_in.oe_n && pins_in.rst_n;
      busy = $realtime < busy_to;
      act = !pins_in.we_n && !pins_in.ce_n;
      if (!pins_in.rst_n) begin
        h.delete();
        wbs = 0;
        busy_to = 0.0;
        busy = 1'b0;
      end else if (pw && !act) begin
        wr(pins_in.addr, data_bus_in);
      end
      if (sel && (!was || pins_in.addr != ca)) begin
        tog = busy ? ~tog : tog;
        acc = (pv && pins_in.addr[21:4] == ca[21:4]) ? T_PAGE_NS : T_RANDOM_NS;
        t0 = $realtime - 0.5;
        ca = pins_in.addr;
        pv = 1'b1;
      end
      if (!sel) data_bus_out = ~data_bus_out;
      else if (busy) data_bus_out = {9'h000, tog, 6'h00};
      else if ($realtime - t0 >= acc - 1.0) data_bus_out = rdm(ca);
      else data_bus_out = ~rdm(ca);
      ready_busy_out = !busy;
      was = sel;
      pw = act;
      #1;
    end
  end
endmodule

// >>> nor_flash_host_bench.sv
/*
  self-checking bench: host controller against the flash model.
  assumes the package's page size and read latencies.
*/
`timescale 1ns/100ps
module nor_flash_host_bench
  import nor_host_pkg::*;
;
  logic              mclk_in = 1'b0;
  logic              rst_n_in = 1'b0;
  logic              ce_in = 1'b1;
  logic              req_valid_in = 1'b0;
  req_t              req_in = '0;
  logic              req_ready_out, rsp_valid_out, rsp_refused_out;
  logic              ready_busy_in;
  logic [DATA_W-1:0] rsp_data_out, dq_in, fl_dq, q;
  logic              buf_wr_in = 1'b0;
  logic [BUF_AW-1:0] buf_addr_in = '0;
  logic [DATA_W-1:0] buf_data_in = '0;
  logic              write_protect_n_in = 1'b1;
  logic              rf;
  pins_t             pins_out;
  int                lat, failures = 0, check_count = 0;

  always #5 mclk_in = ~mclk_in;
  assign dq_in = pins_out.dq_oe ? pins_out.dq_o : fl_dq;

  nor_flash_host dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_data_out(rsp_data_out), .rsp_refused_out(rsp_refused_out),
    .buf_wr_in(buf_wr_in), .buf_addr_in(buf_addr_in),
    .buf_data_in(buf_data_in), .pins_out(pins_out), .dq_in(dq_in),
    .ready_busy_in(ready_busy_in),
    .write_protect_n_in(write_protect_n_in));
  nor_flash_model flash (
    .pins_in(pins_out), .data_bus_in(dq_in),
    .write_protect_n_in(write_protect_n_in), .data_bus_out(fl_dq),
    .ready_busy_out(ready_busy_in));

  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic close_out();
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stall();
    failures++;
    $display("CHECK FAILED %0t handshake timed out", $time);
    close_out();
  endtask
  // entered and left at a falling edge
  task automatic run(input op_t o, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [BUF_AW-1:0] n);
    int i;
    for (i = 0; i < 200 && req_ready_out !== 1'b1; i++) @(negedge mclk_in);
    if (i == 200) stall();
    req_in = '{o, a, d, n};
    req_valid_in = 1'b1;
    @(negedge mclk_in);
    req_valid_in = 1'b0;
    for (lat = 1; lat < 40000 && rsp_valid_out !== 1'b1; lat++) begin
      @(negedge mclk_in);
    end
    if (lat == 40000) stall();
    q = rsp_data_out;
    rf = rsp_refused_out;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    run(OP_READ, a, '0, '0);
    chk(q, e);
  endtask
  task automatic wo(input op_t o, input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] d, input logic [BUF_AW-1:0] n,
                    input logic e);
    run(o, a, d, n);
    chk(rf, e);
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_reads();
    int l1;
    rd(22'h01_2345, 16'hFFFF);
    l1 = lat;
    rd(22'h01_234A, 16'hFFFF);
    chk(l1 - lat, CYC_RANDOM - CYC_PAGE);
    rd(22'h01_2350, 16'hFFFF);
    chk(lat, l1);
  endtask
  task automatic t_protect();
    write_protect_n_in = 1'b0;
    wo(OP_PROGRAM, 22'h00_8010, 16'h1234, '0, 1'b0);
    rd(22'h00_8010, 16'h1234);
    wo(OP_PROGRAM, 22'h00_0010, 16'h0000, '0, 1'b1);
    wo(OP_BLOCK_ERASE, 22'h00_7FFF, '0, '0, 1'b1);
    wo(OP_SECTOR_ERASE, 22'h00_F000, '0, '0, 1'b0);
    rd(22'h00_0010, 16'hFFFF);
    write_protect_n_in = 1'b1;
    wo(OP_PROGRAM, 22'h00_0010, 16'h5A5A, '0, 1'b0);
    rd(22'h00_0010, 16'h5A5A);
  endtask
  task automatic t_erase();
    wo(OP_PROGRAM, 22'h02_3456, 16'hA5C3, '0, 1'b0);
    wo(OP_PROGRAM, 22'h02_2FFF, 16'h1111, '0, 1'b0);
    wo(OP_PROGRAM, 22'h02_8000, 16'h2222, '0, 1'b0);
    wo(OP_SECTOR_ERASE, 22'h02_3ABC, '0, '0, 1'b0);
    rd(22'h02_3456, 16'hFFFF);
    rd(22'h02_2FFF, 16'h1111);
    wo(OP_BLOCK_ERASE, 22'h02_7000, '0, '0, 1'b0);
    rd(22'h02_2FFF, 16'hFFFF);
    rd(22'h02_8000, 16'h2222);
    rd(22'h00_8010, 16'h1234);
  endtask
  task automatic t_buffer();
    for (int i = 0; i < 4; i++) begin
      buf_wr_in = 1'b1;
      buf_addr_in = BUF_AW'(i);
      buf_data_in = 16'hB000 + DATA_W'(i);
      @(negedge mclk_in);
    end
    buf_wr_in = 1'b0;
    wo(OP_BUF_PROGRAM, 22'h03_0000, '0, 4'h3, 1'b0);
    for (int i = 0; i < 5; i++) begin
      rd(22'h03_0000 + ADDR_W'(i),
         i < 4 ? 16'hB000 + DATA_W'(i) : 16'hFFFF);
    end
  endtask
  task automatic t_reset();
    wo(OP_RESET, '0, '0, '0, 1'b0);
    chk(lat > CYC_RST, 1);
    rd(22'h00_8010, 16'h1234);
  endtask
  // clock enable held low in the middle of a program sequence
  task automatic t_freeze();
    fork
      wo(OP_PROGRAM, 22'h04_0000, 16'h0F0F, '0, 1'b0);
      begin
        repeat (30) @(negedge mclk_in);
        ce_in = 1'b0;
        repeat (20) @(negedge mclk_in);
        ce_in = 1'b1;
      end
    join
    rd(22'h04_0000, 16'h0F0F);
  endtask

  initial begin
    repeat (16) @(negedge mclk_in);
    rst_n_in = 1'b1;
    @(negedge mclk_in);
    t_reads();
    t_protect();
    t_erase();
    t_buffer();
    t_reset();
    t_freeze();
    close_out();
  end
endmodule

bind nor_flash_host nor_flash_host_assertions u_chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
  .req_valid_in(req_valid_in), .req_in(req_in),
  .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
  .rsp_refused_out(rsp_refused_out), .pins_out(pins_out),
  .ready_busy_in(ready_busy_in), .write_protect_n_in(write_protect_n_in));
